// File: design/scm_consts.vh
// Notes on behaviour
// - A valid first command selects the serial interface until power-on reset.
// - Without an earlier command, an active select level picks the second interface.
// - After power-up the core loads configuration, powers off, then sleeps.
// - Normal operation sleeps after measuring; periodic operation stays powered through the interval, then measures again.
// - Command mode is entered only when its command comes first.
// - Command mode stays awake until the enter-normal command arrives.
// - Commands 00 to 39 read that user word, returning 16 bits.
// - Commands 3A to 3F read the reserved region, which is never written.
// - Commands 40 to 79 plus a word write to address command minus 40.
// - Command 90 computes a checksum over words 00 to 38 and stores it at 39.
// - Commands A0 to A7 plus a word do one raw conversion.
// - Command A8 is accepted only in command mode and enters normal mode.
// - Command AA runs four passes and returns the second and fourth pass results as two 24-bit values.
// - Command AB repeats full measurements with the cycle interval between them.
// - Every response begins with a status byte, then the data.
// - Commands AD, AE, AF average 4, 8 or 16 measurements without pause.
// - Command BF halts periodic measurement; outside command mode it returns to sleep.
// - B0 selects setup word one, clears status bit 1; B1 selects two, sets it.
// - Select transitions during the start-up sequence never pick the interface.
`ifndef SCM_CONSTS_VH
`define SCM_CONSTS_VH
`define SCM_RD_LAST 8'h39
`define SCM_RSV_LAST 8'h3f
`define SCM_WR_FIRST 8'h40
`define SCM_WR_LAST 8'h79
`define SCM_CMD_CRC 8'h90
`define SCM_RAW_FIRST 8'ha0
`define SCM_RAW_LAST 8'ha7
`define SCM_CMD_NOM 8'ha8
`define SCM_CMD_CM 8'ha9
`define SCM_CMD_MEAS 8'haa
`define SCM_CMD_CYC 8'hab
`define SCM_CMD_OVS4 8'had
`define SCM_CMD_OVS8 8'hae
`define SCM_CMD_OVS16 8'haf
`define SCM_CMD_SEL1 8'hb0
`define SCM_CMD_SEL2 8'hb1
`define SCM_CMD_HALT 8'hbf
`define SCM_CRC_ADDR 6'h39
`define SCM_IFC_ADDR 6'h02
`define SCM_CYC_HI 14
`define SCM_CYC_LO 12
`define SCM_MEM_WORDS 64
`define SCM_REPS1 5'h01
`define SCM_REPS4 5'h04
`define SCM_REPS8 5'h08
`define SCM_REPS16 5'h10
`define SCM_INIT_CYCLES 8'h10
`define SCM_CYC_UNIT 16'h0100
`define SCM_STAT_BUSY 5
`define SCM_STAT_CM 3
`define SCM_STAT_CFG 1
`define SCM_CRC_POLY 16'h1021
`define SCM_CRC_SEED 16'hffff
`endif

// File: design/scm_mem.v
`include "scm_consts.vh"
module scm_mem (
	clk,
	rstn,
	wr_en,
	wr_addr,
	wr_data,
	rd_addr,
	rd_data
);
	input wire clk;
	input wire rstn;
	input wire wr_en;
	input wire [5:0] wr_addr;
	input wire [15:0] wr_data;
	input wire [5:0] rd_addr;
	output wire [15:0] rd_data;
	reg [15:0] mem [0:`SCM_MEM_WORDS-1];
	genvar g;
	generate
		for (g = 0; g < `SCM_MEM_WORDS; g = g + 1) begin : w
			always @(posedge clk or negedge rstn) begin
				if (!rstn)
					mem[g] <= 16'h0000;
				else if (wr_en && wr_addr == g)
					mem[g] <= wr_data;
			end
		end
	endgenerate
	assign rd_data = mem[rd_addr];
endmodule

// File: design/scm_ctrl.v
`include "scm_consts.vh"
module scm_ctrl (
	clk,
	rstn,
	cmd_valid,
	cmd_byte,
	cmd_word,
	i2c_cmd_seen,
	sel_active,
	meas_done,
	meas_result,
	core_power,
	meas_start,
	meas_pass,
	raw_mode,
	if_spi,
	if_locked,
	command_mode,
	sleeping,
	setup_select,
	resp_valid,
	resp_status,
	resp_data
);
	input wire clk;
	input wire rstn;
	input wire cmd_valid;
	input wire [7:0] cmd_byte;
	input wire [15:0] cmd_word;
	input wire i2c_cmd_seen;
	input wire sel_active;
	input wire meas_done;
	input wire [23:0] meas_result;
	output wire core_power;
	output reg meas_start;
	output reg [3:0] meas_pass;
	output reg raw_mode;
	output reg if_spi;
	output reg if_locked;
	output reg command_mode;
	output wire sleeping;
	output reg setup_select;
	output reg resp_valid;
	output reg [7:0] resp_status;
	output reg [47:0] resp_data;

	localparam ST_INIT = 7'h01;
	localparam ST_SLEEP = 7'h02;
	localparam ST_ACTIVE = 7'h04;
	localparam ST_MEAS = 7'h08;
	localparam ST_WAIT = 7'h10;
	localparam ST_PAUSE = 7'h20;
	localparam ST_CRC = 7'h40;

	reg [6:0] state;
	reg [7:0] init_cnt;
	reg [1:0] sel_sync;
	reg [1:0] i2c_sync;
	reg first_done;
	reg cyclic;
	reg raw_req;
	reg [1:0] pass_idx;
	reg [4:0] reps_left;
	reg [4:0] reps_total;
	reg [27:0] acc_s;
	reg [27:0] acc_t;
	reg [23:0] last_s;
	reg [18:0] pause_cnt;
	reg [2:0] cyc_hold;
	reg [5:0] crc_addr;
	reg [15:0] crc;
	reg mem_we;
	reg [5:0] mem_waddr;
	reg [15:0] mem_wdata;
	wire [15:0] mem_rdata;
	reg [5:0] mem_raddr;

	function is_read;
		input [7:0] c;
		is_read = (c <= `SCM_RSV_LAST);
	endfunction

	function [15:0] crc_step;
		input [15:0] c;
		input [15:0] d;
		integer i;
		reg [15:0] r;
		begin
			r = c ^ d;
			for (i = 0; i < 16; i = i + 1)
				r = r[15] ? ((r << 1) ^ `SCM_CRC_POLY) : (r << 1);
			crc_step = r;
		end
	endfunction

	scm_mem u_mem (
		.clk(clk),
		.rstn(rstn),
		.wr_en(mem_we),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata),
		.rd_addr(mem_raddr),
		.rd_data(mem_rdata)
	);

	assign core_power = (state != ST_SLEEP);
	assign sleeping = (state == ST_SLEEP);

	// Host reads take the read port ahead of the checksum walk
	wire rd_take = cmd_valid && (state != ST_INIT) && is_read(cmd_byte);

	always @* begin
		mem_raddr = `SCM_IFC_ADDR;
		if (rd_take)
			mem_raddr = cmd_byte[5:0];
		else if (state == ST_CRC)
			mem_raddr = crc_addr;
	end

	wire busy = (state == ST_MEAS) || (state == ST_WAIT) || (state == ST_CRC) || (state == ST_INIT);
	wire [7:0] status = {2'b00, busy, 1'b0, command_mode, 1'b0, setup_select, 1'b0};
	wire [2:0] cyc_field = mem_rdata[`SCM_CYC_HI:`SCM_CYC_LO];
	wire is_write = (cmd_byte >= `SCM_WR_FIRST) && (cmd_byte <= `SCM_WR_LAST);
	wire is_raw = (cmd_byte >= `SCM_RAW_FIRST) && (cmd_byte <= `SCM_RAW_LAST);
	wire is_full = (cmd_byte == `SCM_CMD_MEAS) || (cmd_byte == `SCM_CMD_CYC) ||
		(cmd_byte >= `SCM_CMD_OVS4 && cmd_byte <= `SCM_CMD_OVS16);
	wire can_run = (state == ST_SLEEP) || (state == ST_ACTIVE) || (state == ST_PAUSE);
	wire [7:0] wr_off = cmd_byte - `SCM_WR_FIRST;
	wire [5:0] wr_addr_cmd = wr_off[5:0];

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sel_sync <= 2'b00;
			i2c_sync <= 2'b00;
		end else begin
			sel_sync <= {sel_sync[0], sel_active};
			i2c_sync <= {i2c_sync[0], i2c_cmd_seen};
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_INIT;
			init_cnt <= 8'h00;
			if_spi <= 1'b0;
			if_locked <= 1'b0;
			first_done <= 1'b0;
			command_mode <= 1'b0;
			cyclic <= 1'b0;
			setup_select <= 1'b0;
			raw_req <= 1'b0;
			raw_mode <= 1'b0;
			meas_start <= 1'b0;
			meas_pass <= 4'h0;
			pass_idx <= 2'd0;
			reps_left <= 5'd0;
			reps_total <= 5'd0;
			acc_s <= 28'h0;
			acc_t <= 28'h0;
			last_s <= 24'h0;
			pause_cnt <= 19'h0;
			cyc_hold <= 3'h0;
			crc_addr <= 6'h00;
			crc <= `SCM_CRC_SEED;
			mem_we <= 1'b0;
			mem_waddr <= 6'h00;
			mem_wdata <= 16'h0000;
			resp_valid <= 1'b0;
			resp_status <= 8'h00;
			resp_data <= 48'h0;
		end else begin
			meas_start <= 1'b0;
			mem_we <= 1'b0;
			resp_valid <= 1'b0;
			// Keep the cycle field while the read port shows its word
			if (!rd_take && state != ST_CRC)
				cyc_hold <= cyc_field;
			// Interface choice once start-up is over
			if (state != ST_INIT && !if_locked) begin
				if (i2c_sync[1]) begin
					if_locked <= 1'b1;
				end else if (sel_sync[1]) begin
					if_locked <= 1'b1;
					if_spi <= 1'b1;
				end
			end
			case (state)
			ST_INIT: begin
				init_cnt <= init_cnt + 8'h01;
				if (init_cnt == `SCM_INIT_CYCLES)
					state <= ST_SLEEP;
			end
			ST_CRC: begin
				// Step waits while a host read holds the port
				if (!rd_take) begin
					crc <= crc_step(crc, mem_rdata);
					crc_addr <= crc_addr + 6'h01;
					if (crc_addr == `SCM_CRC_ADDR - 6'h01) begin
						mem_we <= 1'b1;
						mem_waddr <= `SCM_CRC_ADDR;
						mem_wdata <= crc_step(crc, mem_rdata);
						state <= command_mode ? ST_ACTIVE : ST_SLEEP;
					end
				end
			end
			ST_MEAS: begin
				meas_start <= 1'b1;
				meas_pass <= 4'h1 << pass_idx;
				state <= ST_WAIT;
			end
			ST_WAIT: begin
				if (meas_done) begin
					if (raw_req) begin
						resp_valid <= 1'b1;
						resp_status <= status;
						resp_data <= {meas_result, 24'h0};
						state <= command_mode ? ST_ACTIVE : ST_SLEEP;
					end else if (pass_idx != 2'd3) begin
						if (pass_idx == 2'd1)
							last_s <= meas_result;
						pass_idx <= pass_idx + 2'd1;
						state <= ST_MEAS;
					end else begin
						acc_s <= acc_s + {4'h0, last_s};
						acc_t <= acc_t + {4'h0, meas_result};
						pass_idx <= 2'd0;
						if (reps_left != 5'd1) begin
							reps_left <= reps_left - 5'd1;
							state <= ST_MEAS;
						end else begin
							resp_valid <= 1'b1;
							resp_status <= status;
							resp_data <= mean_out(acc_s + {4'h0, last_s},
								acc_t + {4'h0, meas_result}, reps_total);
							acc_s <= 28'h0;
							acc_t <= 28'h0;
							if (cyclic) begin
								pause_cnt <= {cyc_hold, 16'h0000} + {3'b000, `SCM_CYC_UNIT};
								state <= ST_PAUSE;
							end else
								state <= command_mode ? ST_ACTIVE : ST_SLEEP;
						end
					end
				end
			end
			ST_PAUSE: begin
				pause_cnt <= pause_cnt - 19'h1;
				if (pause_cnt == 19'h1) begin
					reps_left <= 5'd1;
					state <= ST_MEAS;
				end
			end
			default: ;
			endcase
			if (cmd_valid && state != ST_INIT) begin
				if (!first_done)
					first_done <= 1'b1;
				if (is_read(cmd_byte)) begin
					resp_valid <= 1'b1;
					resp_status <= status;
					resp_data <= {mem_rdata, 32'h0};
				end else if (is_write && can_run) begin
					mem_we <= 1'b1;
					mem_waddr <= wr_addr_cmd;
					mem_wdata <= cmd_word;
				end else if (cmd_byte == `SCM_CMD_CRC && can_run) begin
					crc <= `SCM_CRC_SEED;
					crc_addr <= 6'h00;
					state <= ST_CRC;
				end else if (is_raw && can_run) begin
					raw_req <= 1'b1;
					raw_mode <= cmd_byte[0];
					pass_idx <= cmd_byte[2] ? 2'd3 : 2'd1;
					state <= ST_MEAS;
				end else if (cmd_byte == `SCM_CMD_NOM && command_mode) begin
					command_mode <= 1'b0;
					state <= ST_SLEEP;
				end else if (cmd_byte == `SCM_CMD_CM && !first_done) begin
					command_mode <= 1'b1;
					state <= ST_ACTIVE;
				end else if (is_full && can_run) begin
					raw_req <= 1'b0;
					pass_idx <= 2'd0;
					cyclic <= (cmd_byte == `SCM_CMD_CYC);
					reps_left <= rep_count(cmd_byte);
					reps_total <= rep_count(cmd_byte);
					state <= ST_MEAS;
				end else if (cmd_byte == `SCM_CMD_SEL1) begin
					setup_select <= 1'b0;
				end else if (cmd_byte == `SCM_CMD_SEL2) begin
					setup_select <= 1'b1;
				end else if (cmd_byte == `SCM_CMD_HALT) begin
					cyclic <= 1'b0;
					if (!command_mode)
						state <= ST_SLEEP;
					else if (state == ST_PAUSE)
						state <= ST_ACTIVE;
				end
				// Anything else is dropped here
			end
		end
	end

	function [4:0] rep_count;
		input [7:0] c;
		case (c)
		`SCM_CMD_OVS4: rep_count = `SCM_REPS4;
		`SCM_CMD_OVS8: rep_count = `SCM_REPS8;
		`SCM_CMD_OVS16: rep_count = `SCM_REPS16;
		default: rep_count = `SCM_REPS1;
		endcase
	endfunction

	function [47:0] mean_out;
		input [27:0] s;
		input [27:0] t;
		input [4:0] n;
		case (n)
		`SCM_REPS4: mean_out = {s[25:2], t[25:2]};
		`SCM_REPS8: mean_out = {s[26:3], t[26:3]};
		`SCM_REPS16: mean_out = {s[27:4], t[27:4]};
		default: mean_out = {s[23:0], t[23:0]};
		endcase
	endfunction
endmodule

// File: bench/scm_ctrl_properties.sv
module scm_ctrl_props (
	input logic clk,
	input logic rstn,
	input logic cmd_valid,
	input logic [7:0] cmd_byte,
	input logic [15:0] cmd_word,
	input logic i2c_cmd_seen,
	input logic sel_active,
	input logic meas_done,
	input logic [23:0] meas_result,
	input logic core_power,
	input logic meas_start,
	input logic [3:0] meas_pass,
	input logic raw_mode,
	input logic if_spi,
	input logic if_locked,
	input logic command_mode,
	input logic sleeping,
	input logic setup_select,
	input logic resp_valid,
	input logic [7:0] resp_status,
	input logic [47:0] resp_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] age;
	logic rdy;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Cycles since reset, saturating
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			age <= 5'h0;
		else if (age != 5'h1f)
			age <= age + 5'h1;
	end
	assign rdy = age >= 5'h14;
	a_read_answer: assert property (rdy && cmd_valid && cmd_byte <= 8'h3f
		|=> resp_valid && resp_data[31:0] == 32'h0) else $error("read not answered");
	a_status_setup: assert property (resp_valid
		|-> resp_status[1] == $past(setup_select)) else $error("status setup bit wrong");
	a_b1_sets: assert property (rdy && cmd_valid && cmd_byte == 8'hb1
		|=> setup_select) else $error("setup select not set");
	a_b0_clears: assert property (rdy && cmd_valid && cmd_byte == 8'hb0
		|=> !setup_select) else $error("setup select not cleared");
	a_pass_onehot: assert property (meas_start |-> $onehot(meas_pass))
		else $error("pass not one-hot");
	a_sleep_core_off: assert property (sleeping |-> !core_power)
		else $error("core powered in sleep");
	a_lock_holds: assert property (if_locked |=> if_locked && $stable(if_spi))
		else $error("interface choice changed");
	a_no_early_lock: assert property (age < 5'h10 |-> !if_locked)
		else $error("interface locked during init");
	a_cm_awake: assert property (command_mode |-> !sleeping)
		else $error("asleep in command mode");
	a_nom_refused: assert property (!command_mode && cmd_valid && cmd_byte == 8'ha8
		|=> !command_mode) else $error("mode changed by refused command");
	a_measure_starts: assert property (rdy && sleeping && cmd_valid
		&& cmd_byte == 8'haa |-> ##[1:3] meas_start && meas_pass == 4'h1)
		else $error("no offset pass");
	a_cm_entry: assert property ($rose(command_mode)
		|-> $past(cmd_valid) && $past(cmd_byte) == 8'ha9) else $error("command mode entered wrongly");
	a_halt_sleeps: assert property (rdy && !command_mode && cmd_valid
		&& cmd_byte == 8'hbf |=> sleeping) else $error("halt did not sleep");
	c_read: cover property (resp_valid && resp_data[31:0] == 32'h0);
	c_meas: cover property (meas_done ##1 resp_valid);
	c_lock: cover property ($rose(if_locked));
endmodule
bind scm_ctrl scm_ctrl_props i_scm_ctrl_props (
	.clk(clk),
	.rstn(rstn),
	.cmd_valid(cmd_valid),
	.cmd_byte(cmd_byte),
	.cmd_word(cmd_word),
	.i2c_cmd_seen(i2c_cmd_seen),
	.sel_active(sel_active),
	.meas_done(meas_done),
	.meas_result(meas_result),
	.core_power(core_power),
	.meas_start(meas_start),
	.meas_pass(meas_pass),
	.raw_mode(raw_mode),
	.if_spi(if_spi),
	.if_locked(if_locked),
	.command_mode(command_mode),
	.sleeping(sleeping),
	.setup_select(setup_select),
	.resp_valid(resp_valid),
	.resp_status(resp_status),
	.resp_data(resp_data)
);

// File: bench/scm_afe_model.sv
module scm_afe_model #(parameter int LAT = 3) (
	input logic clk,
	input logic rstn,
	input logic meas_start,
	input logic [3:0] meas_pass,
	output logic meas_done,
	output logic [23:0] meas_result
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	logic [3:0] pass;
	// Result tagged by pass; stale value inverted between answers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			pass <= 4'h0;
			meas_done <= 1'b0;
			meas_result <= 24'h0;
		end else begin
			meas_done <= 1'b0;
			meas_result <= ~meas_result;
			if (meas_start) begin
				cnt <= LAT;
				pass <= meas_pass;
			end else if (cnt == 1) begin
				cnt <= 0;
				meas_done <= 1'b1;
				meas_result <= {pass, 20'h5a5a5};
			end else if (cnt > 1)
				cnt <= cnt - 1;
		end
	end
endmodule

// File: bench/scm_ctrl_tb.sv
module scm_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, cmd_valid, i2c_cmd_seen, sel_active, meas_done, core_power, meas_start;
	logic raw_mode, if_spi, if_locked, command_mode, sleeping, setup_select, resp_valid;
	logic [7:0] cmd_byte, resp_status;
	logic [15:0] cmd_word;
	logic [15:0] seq = 16'h0;
	logic [23:0] meas_result;
	logic [3:0] meas_pass;
	logic [47:0] resp_data;
	int mismatches, total_checks;
	int nst = 0;
	int cyc = 0;
	scm_ctrl i_scm_ctrl (
		.clk(clk),
		.rstn(rstn),
		.cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte),
		.cmd_word(cmd_word),
		.i2c_cmd_seen(i2c_cmd_seen),
		.sel_active(sel_active),
		.meas_done(meas_done),
		.meas_result(meas_result),
		.core_power(core_power),
		.meas_start(meas_start),
		.meas_pass(meas_pass),
		.raw_mode(raw_mode),
		.if_spi(if_spi),
		.if_locked(if_locked),
		.command_mode(command_mode),
		.sleeping(sleeping),
		.setup_select(setup_select),
		.resp_valid(resp_valid),
		.resp_status(resp_status),
		.resp_data(resp_data)
	);
	scm_afe_model i_scm_afe_model (
		.clk(clk),
		.rstn(rstn),
		.meas_start(meas_start),
		.meas_pass(meas_pass),
		.meas_done(meas_done),
		.meas_result(meas_result)
	);
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (meas_start) begin
			seq <= {seq[11:0], meas_pass};
			nst <= nst + 1;
		end
	end
	task chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bitwise checksum over words 00-38, only word 05 non-zero
	function automatic logic [15:0] crc_ref(input logic [15:0] w5);
		logic [15:0] r;
		logic fb;
		r = 16'hffff;
		for (int a = 0; a < 57; a++)
			for (int b = 15; b >= 0; b--) begin
				fb = r[15] ^ ((a == 5) ? w5[b] : 1'b0);
				r = {r[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
			end
		return r;
	endfunction
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task send(input logic [7:0] b, input logic [15:0] w);
		@(posedge clk) #1;
		cmd_valid = 1'b1;
		cmd_byte = b;
		cmd_word = w;
		@(posedge clk) #1;
		cmd_valid = 1'b0;
	endtask
	task wresp;
		for (int i = 0; i < 2000 && resp_valid !== 1'b1; i++)
			@(posedge clk) #1;
		if (resp_valid !== 1'b1) begin
			mismatches++;
			close_out;
		end
	endtask
	task t_ifc;
		chk(if_locked, 0);
		i2c_cmd_seen = 1'b1;
		repeat (6) @(posedge clk) #1;
		sel_active = 1'b1;
		repeat (6) @(posedge clk) #1;
		chk({if_locked, if_spi}, 2'b10);
		$display("ifc done");
	endtask
	task t_cm;
		send(8'ha9, 16'h0);
		chk(command_mode, 1);
		repeat (40) @(posedge clk) #1;
		chk(sleeping, 0);
		$display("cm done");
	endtask
	task t_mem;
		send(8'h45, 16'h1234);
		send(8'h79, 16'hbeef);
		send(8'h05, 16'h0);
		chk(resp_data, {16'h1234, 32'h0});
		send(8'h39, 16'h0);
		chk(resp_data[47:32], 16'hbeef);
		send(8'h3a, 16'h0);
		chk(resp_valid, 1);
		chk(resp_data, 48'h0);
		send(8'h90, 16'h0);
		repeat (300) @(posedge clk) #1;
		send(8'h39, 16'h0);
		chk(resp_data[47:32], crc_ref(16'h1234));
		$display("mem done");
	endtask
	task t_sel;
		send(8'hb1, 16'h0);
		chk(setup_select, 1);
		send(8'h05, 16'h0);
		chk(resp_status[1], 1);
		send(8'hb0, 16'h0);
		chk(setup_select, 0);
		$display("sel done");
	endtask
	task t_meas;
		int n0;
		send(8'ha0, 16'h0);
		wresp;
		chk({seq[3:0], raw_mode}, 5'h4);
		chk(resp_data, {4'h2, 20'h5a5a5, 24'h0});
		send(8'ha1, 16'h0);
		wresp;
		chk(raw_mode, 1);
		chk(resp_data, {4'h2, 20'h5a5a5, 24'h0});
		send(8'haa, 16'h0);
		wresp;
		chk(seq, 16'h1248);
		chk(resp_data, {24'h25a5a5, 24'h85a5a5});
		n0 = nst;
		send(8'had, 16'h0);
		wresp;
		chk(nst - n0, 16);
		chk(resp_data, {24'h25a5a5, 24'h85a5a5});
		$display("meas done");
	endtask
	task t_nom;
		int c0;
		int n0;
		send(8'ha8, 16'h0);
		chk(command_mode, 0);
		send(8'ha8, 16'h0);
		chk({command_mode, sleeping}, 2'b01);
		send(8'ha9, 16'h0);
		chk(command_mode, 0);
		send(8'haa, 16'h0);
		wresp;
		chk(resp_data, {24'h25a5a5, 24'h85a5a5});
		repeat (3) @(posedge clk) #1;
		chk(sleeping, 1);
		send(8'hab, 16'h0);
		wresp;
		c0 = cyc;
		@(posedge clk) #1;
		wresp;
		chk(resp_valid, 1);
		chk((cyc - c0 >= 256) && (cyc - c0 <= 320), 1);
		chk(resp_data, {24'h25a5a5, 24'h85a5a5});
		send(8'hbf, 16'h0);
		n0 = nst;
		repeat (400) @(posedge clk) #1;
		chk(sleeping, 1);
		chk(nst - n0, 0);
		$display("nom done");
	endtask
	task t_spi;
		// Second start-up: select goes active first this time
		rstn = 1'b0;
		i2c_cmd_seen = 1'b0;
		sel_active = 1'b0;
		repeat (3) @(posedge clk) #1;
		rstn = 1'b1;
		repeat (2) @(posedge clk) #1;
		chk({core_power, sleeping, if_locked}, 3'b100);
		repeat (20) @(posedge clk) #1;
		chk({core_power, sleeping, if_locked}, 3'b010);
		sel_active = 1'b1;
		repeat (6) @(posedge clk) #1;
		chk({if_locked, if_spi}, 2'b11);
		$display("spi done");
	endtask
	initial begin
		clk = 0;
		rstn = 0;
		cmd_valid = 0;
		cmd_byte = 8'h0;
		cmd_word = 16'h0;
		i2c_cmd_seen = 0;
		sel_active = 1;
		repeat (3) @(posedge clk) #1;
		rstn = 1;
		// Select toggles inside init must not pick the interface
		repeat (8) @(posedge clk) #1;
		sel_active = 0;
		repeat (15) @(posedge clk) #1;
		t_ifc;
		t_cm;
		t_mem;
		t_sel;
		t_meas;
		t_nom;
		t_spi;
		close_out;
	end
endmodule
